// ---- hw/rmsel_pkg.sv ----
// Constants, register map and channel layout of the remappable input select.
// Assumes a 32-bit AXI4-Lite register bus and one synchronous clock.
package rmsel_pkg;
    localparam int unsigned ADDR_W   = 6;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned STRB_W   = 4;
    localparam int unsigned REG_W    = 16;
    localparam int unsigned NUM_REGS = 10;
    localparam int unsigned NUM_SLOT = 20;
    localparam int unsigned NUM_CH   = 17;
    localparam int unsigned FLD_W    = 5;
    localparam int unsigned NUM_PINS = 26;
    localparam int unsigned LO_POS   = 0;
    localparam int unsigned HI_POS   = 8;
    localparam int unsigned IDX_LSB  = 2;
    localparam int unsigned IDX_W    = 4;

    // Byte address of a register is four times its index.
    localparam logic [IDX_W-1:0]    IDX_CAP12    = 4'h0;
    localparam logic [IDX_W-1:0]    IDX_STATUS   = 4'hA;
    localparam logic [IDX_W-1:0]    IDX_SEL_LIM  = 4'hA;

    // Bit k set when register k holds a second field in bits 12-8.
    localparam logic [NUM_REGS-1:0] REG_HAS_HI   = 10'h17B;
    localparam logic [REG_W-1:0]    MASK_TWO     = 16'h1F1F;
    localparam logic [REG_W-1:0]    MASK_ONE     = 16'h001F;
    localparam logic [FLD_W-1:0]    PIN_LIM      = 5'h1A;

    // Level a peripheral input sees when no usable pin feeds it.
    localparam logic [NUM_CH-1:0]   CH_IDLE      = 17'h1_2780;

    // Field slot (register index times two, plus one for bits 12-8).
    localparam int unsigned CH_SLOT [NUM_CH] =
        '{0, 1, 2, 3, 4, 6, 7, 8, 9, 10, 11, 12, 13, 14, 16, 17, 18};

    localparam logic [1:0]          RESP_OKAY    = 2'h0;
    localparam logic [1:0]          RESP_SLVERR  = 2'h2;

    typedef logic [FLD_W-1:0] rmsel_fld_t;
endpackage : rmsel_pkg

// ---- hw/rmsel_route_if.sv ----
// Selection fields going to the router and routed levels coming back.
// Assumes both ends share one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface rmsel_route_if;
    import rmsel_pkg::*;
    rmsel_fld_t        sel [NUM_CH];
    logic [NUM_CH-1:0] chan;
    modport cfg (output sel, input chan);
    modport rtr (input sel, output chan);
endinterface : rmsel_route_if
`default_nettype wire

// ---- hw/rmsel_field_reg.sv ----
// One 16-bit selection register with one or two 5-bit fields.
// Assumes the caller qualifies the write with the lock state.
`timescale 1ns/1ps
`default_nettype none
module rmsel_field_reg
    import rmsel_pkg::*;
#(
    parameter logic HAS_HI = 1'b1
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             ce,
    input  wire logic             wr_en,
    input  wire logic [REG_W-1:0] wdata,
    input  wire logic [1:0]       be,
    output logic      [REG_W-1:0] q
);
    localparam logic [REG_W-1:0] IMPL = HAS_HI ? MASK_TWO : MASK_ONE;

    logic [REG_W-1:0] reg_ff;
    logic [REG_W-1:0] nxt_reg;
    logic [REG_W-1:0] lane;

    always_comb begin
        lane    = {{8{be[1]}}, {8{be[0]}}};
        nxt_reg = reg_ff;
        if (wr_en) begin
            nxt_reg = ((wdata & lane) | (reg_ff & ~lane)) & IMPL;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reg_ff <= IMPL;
        end else if (ce) begin
            reg_ff <= nxt_reg;
        end
    end

    assign q = reg_ff;
endmodule : rmsel_field_reg
`default_nettype wire

// ---- hw/rmsel_router.sv ----
// Per-channel pin multiplexers with registered peripheral inputs.
// Assumes pin levels are synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module rmsel_router
    import rmsel_pkg::*;
(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic                ce,
    input  wire logic [NUM_PINS-1:0] pin_in,
    input  wire logic [NUM_PINS-1:0] pin_analog,
    rmsel_route_if.rtr               rif
);
    logic [NUM_CH-1:0] chan_ff;
    logic [NUM_CH-1:0] nxt_chan;

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        logic pick;
        always_comb begin
            pick = CH_IDLE[i];
            if (rif.sel[i] < PIN_LIM) begin
                if (!pin_analog[rif.sel[i]]) begin
                    pick = pin_in[rif.sel[i]];
                end
            end
        end
        assign nxt_chan[i] = pick;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chan_ff <= CH_IDLE;
        end else if (ce) begin
            chan_ff <= nxt_chan;
        end
    end

    assign rif.chan = chan_ff;
endmodule : rmsel_router
`default_nettype wire

// ---- hw/rmsel_top.sv ----
// Remappable input select: AXI4-Lite register file and routed inputs.
// Assumes pins synchronous to aclk and the lock level from elsewhere.
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module rmsel_top
    import rmsel_pkg::*;
(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic                ce,
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [DATA_W-1:0]   s_axi_wdata,
    input  wire logic [STRB_W-1:0]   s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic [NUM_PINS-1:0] pin_in,
    input  wire logic [NUM_PINS-1:0] pin_analog,
    input  wire logic                pin_config_lock,
    output logic                     capture_channel_one,
    output logic                     capture_channel_two,
    output logic                     capture_channel_three,
    output logic                     capture_channel_four,
    output logic                     capture_channel_five,
    output logic                     compare_fault_a,
    output logic                     compare_fault_b,
    output logic                     uart_a_receive,
    output logic                     uart_a_clear_to_send,
    output logic                     uart_b_receive,
    output logic                     uart_b_clear_to_send,
    output logic                     spi_a_data_in,
    output logic                     spi_a_clock_in,
    output logic                     spi_a_select_in,
    output logic                     spi_b_data_in,
    output logic                     spi_b_clock_in,
    output logic                     spi_b_select_in
);
    rmsel_route_if rif ();

    // Write channel state.
    logic                aw_held_ff;
    logic                nxt_aw_held;
    logic [ADDR_W-1:0]   awaddr_ff;
    logic [ADDR_W-1:0]   nxt_awaddr;
    logic                w_held_ff;
    logic                nxt_w_held;
    logic [DATA_W-1:0]   wdata_ff;
    logic [DATA_W-1:0]   nxt_wdata;
    logic [STRB_W-1:0]   wstrb_ff;
    logic [STRB_W-1:0]   nxt_wstrb;
    logic                bvalid_ff;
    logic                nxt_bvalid;
    logic [1:0]          bresp_ff;
    logic [1:0]          nxt_bresp;
    logic                wr_go;
    logic [IDX_W-1:0]    wr_idx;

    // Read channel state.
    logic                rvalid_ff;
    logic                nxt_rvalid;
    logic [DATA_W-1:0]   rdata_ff;
    logic [DATA_W-1:0]   nxt_rdata;
    logic [1:0]          rresp_ff;
    logic [1:0]          nxt_rresp;
    logic [IDX_W-1:0]    rd_idx;

    // Register file.
    logic [REG_W-1:0]    regs   [NUM_REGS];
    logic [NUM_REGS*REG_W-1:0] regs_flat;
    rmsel_fld_t          slot   [NUM_SLOT];
    logic                aw_fire;
    logic                w_fire;
    logic                ar_fire;

    assign s_axi_awready = ce && !aw_held_ff && !bvalid_ff;
    assign s_axi_wready  = ce && !w_held_ff && !bvalid_ff;
    assign s_axi_arready = ce && !rvalid_ff;
    assign aw_fire       = s_axi_awvalid && s_axi_awready;
    assign w_fire        = s_axi_wvalid && s_axi_wready;
    assign ar_fire       = s_axi_arvalid && s_axi_arready;
    assign wr_go         = ce && aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_idx        = awaddr_ff[IDX_LSB +: IDX_W];
    assign rd_idx        = s_axi_araddr[IDX_LSB +: IDX_W];

    always_comb begin
        nxt_aw_held = aw_held_ff;
        nxt_awaddr  = awaddr_ff;
        nxt_w_held  = w_held_ff;
        nxt_wdata   = wdata_ff;
        nxt_wstrb   = wstrb_ff;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        if (aw_fire) begin
            nxt_aw_held = 1'b1;
            nxt_awaddr  = s_axi_awaddr;
        end
        if (w_fire) begin
            nxt_w_held = 1'b1;
            nxt_wdata  = s_axi_wdata;
            nxt_wstrb  = s_axi_wstrb;
        end
        if (wr_go) begin
            nxt_aw_held = 1'b0;
            nxt_w_held  = 1'b0;
            nxt_bvalid  = 1'b1;
            // A locked write still answers OKAY; the value is kept.
            nxt_bresp   = (wr_idx < IDX_SEL_LIM) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            awaddr_ff  <= '0;
            w_held_ff  <= 1'b0;
            wdata_ff   <= '0;
            wstrb_ff   <= '0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
        end else if (ce) begin
            aw_held_ff <= nxt_aw_held;
            awaddr_ff  <= nxt_awaddr;
            w_held_ff  <= nxt_w_held;
            wdata_ff   <= nxt_wdata;
            wstrb_ff   <= nxt_wstrb;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
        end
    end

    for (genvar k = 0; k < NUM_REGS; k++) begin : g_reg
        logic wr_k;
        assign wr_k = wr_go && !pin_config_lock && (wr_idx == IDX_W'(k));
        rmsel_field_reg #(
            .HAS_HI (REG_HAS_HI[k])
        ) u_reg (
            .aclk    (aclk),
            .aresetn (aresetn),
            .ce      (ce),
            .wr_en   (wr_k),
            .wdata   (wdata_ff[REG_W-1:0]),
            .be      (wstrb_ff[1:0]),
            .q       (regs[k])
        );
        assign slot[2*k]   = regs[k][LO_POS +: FLD_W];
        assign slot[2*k+1] = regs[k][HI_POS +: FLD_W];
        assign regs_flat[k*REG_W +: REG_W] = regs[k];
    end

    // each channel reads its field slot
    for (genvar i = 0; i < NUM_CH; i++) begin : g_sel
        assign rif.sel[i] = slot[CH_SLOT[i]];
    end

    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        if (ar_fire) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = RESP_OKAY;
            nxt_rdata  = '0;
            if (rd_idx < IDX_SEL_LIM) begin
                nxt_rdata = DATA_W'(regs[rd_idx]);
            end else if (rd_idx == IDX_STATUS) begin
                nxt_rdata = DATA_W'({rif.chan, pin_config_lock});
            end else begin
                nxt_rresp = RESP_SLVERR;
            end
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= '0;
            rresp_ff  <= RESP_OKAY;
        end else if (ce) begin
            rvalid_ff <= nxt_rvalid;
            rdata_ff  <= nxt_rdata;
            rresp_ff  <= nxt_rresp;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata  = rdata_ff;
    assign s_axi_rresp  = rresp_ff;

    rmsel_router u_router (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .ce         (ce),
        .pin_in     (pin_in),
        .pin_analog (pin_analog),
        .rif        (rif)
    );

    assign capture_channel_one   = rif.chan[0];
    assign capture_channel_two   = rif.chan[1];
    assign capture_channel_three = rif.chan[2];
    assign capture_channel_four  = rif.chan[3];
    assign capture_channel_five  = rif.chan[4];
    assign compare_fault_a       = rif.chan[5];
    assign compare_fault_b       = rif.chan[6];
    assign uart_a_receive        = rif.chan[7];
    assign uart_a_clear_to_send  = rif.chan[8];
    assign uart_b_receive        = rif.chan[9];
    assign uart_b_clear_to_send  = rif.chan[10];
    assign spi_a_data_in         = rif.chan[11];
    assign spi_a_clock_in        = rif.chan[12];
    assign spi_a_select_in       = rif.chan[13];
    assign spi_b_data_in         = rif.chan[14];
    assign spi_b_clock_in        = rif.chan[15];
    assign spi_b_select_in       = rif.chan[16];

    // Helper levels for the checks below.
    logic chk_cap1;
    logic chk_sspb;
    assign chk_cap1 = pin_in[regs[0][LO_POS +: FLD_W]];
    assign chk_sspb = pin_in[regs[9][LO_POS +: FLD_W]];

    cap_one_route_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ce && regs[0][LO_POS +: FLD_W] < PIN_LIM
            && !pin_analog[regs[0][LO_POS +: FLD_W]]
        |=> capture_channel_one == $past(chk_cap1))
        else $error("capture one does not follow its pin");

    spi_b_sel_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ce && regs[9][LO_POS +: FLD_W] < PIN_LIM
            && !pin_analog[regs[9][LO_POS +: FLD_W]]
        |=> spi_b_select_in == $past(chk_sspb))
        else $error("spi b select does not follow its pin");

    bad_pin_idle_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ce && regs[1][LO_POS +: FLD_W] >= PIN_LIM
        |=> capture_channel_three == CH_IDLE[2])
        else $error("unmapped capture three not idle");

    analog_idle_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ce && regs[4][LO_POS +: FLD_W] < PIN_LIM
            && pin_analog[regs[4][LO_POS +: FLD_W]]
        |=> uart_a_receive == CH_IDLE[7])
        else $error("analog pin reached uart a receive");

    lock_hold_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        pin_config_lock |=> $stable(regs_flat))
        else $error("selection changed while locked");

    unimpl_zero_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (regs[2] & ~MASK_ONE) == '0 && (regs[7] & ~MASK_ONE) == '0
            && (regs[0] & ~MASK_TWO) == '0)
        else $error("unimplemented selection bit set");

    write_lands_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_go && !pin_config_lock && wr_idx == IDX_CAP12 && wstrb_ff[0]
        |=> regs[0][LO_POS +: FLD_W] == $past(wdata_ff[LO_POS +: FLD_W]))
        else $error("capture one field write lost");

    // The register itself changes at the same edge, so only the channel
    // state is checked here: the answer stands and both readies are shut.
    write_answer_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_go |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write response missing");

    read_answer_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ar_fire && rd_idx == IDX_CAP12
        |=> s_axi_rvalid
            && s_axi_rdata[REG_W-1:0] == $past(regs_flat[REG_W-1:0]))
        else $error("read of capture register wrong");
endmodule : rmsel_top
`default_nettype wire

// ---- verification/rmsel_pin_model.sv ----
// Pin-side partner: remappable pin levels and their analog mode flags.
// Assumes the bench chooses which pins sit in analog mode.
`timescale 1ns/1ps
`default_nettype none
module rmsel_pin_model
    import rmsel_pkg::*;
(
    input  wire logic                aclk,
    input  wire logic [NUM_PINS-1:0] analog_req,
    output logic      [NUM_PINS-1:0] pin_in,
    output logic      [NUM_PINS-1:0] pin_analog
);
    // Fresh levels every cycle, so a stale or wrong selection shows quickly.
    initial begin
        pin_in     = '0;
        pin_analog = '0;
        forever begin
            @(posedge aclk);
            pin_in     <= NUM_PINS'($urandom);
            pin_analog <= analog_req;
        end
    end
endmodule : rmsel_pin_model
`default_nettype wire

// ---- verification/rmsel_bench.sv ----
// Self-checking bench for the remappable input select, with a queue-free
// register model and a routing predictor checked every cycle it runs.
// Assumes the pin model drives pins right after each rising edge.
`timescale 1ns/1ps
`default_nettype none
module rmsel_bench;
    import rmsel_pkg::*;
    logic                aclk, aresetn, ce, lock;
    logic [ADDR_W-1:0]   awaddr, araddr;
    logic [DATA_W-1:0]   wdata, rdata, rd;
    logic [STRB_W-1:0]   wstrb;
    logic                awvalid, awready, wvalid, wready, bvalid, bready;
    logic                arvalid, arready, rvalid, rready;
    logic [1:0]          bresp, rresp, resp;
    logic [NUM_CH-1:0]   routed, frz;
    logic [NUM_PINS-1:0] pin_in, pin_analog, pin_p, an_p, an_req;
    int unsigned         exp_reg [NUM_REGS];
    int                  fails, n_checks;

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    rmsel_top dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pin_in(pin_in), .pin_analog(pin_analog), .pin_config_lock(lock),
        .capture_channel_one(routed[0]), .capture_channel_two(routed[1]),
        .capture_channel_three(routed[2]), .capture_channel_four(routed[3]),
        .capture_channel_five(routed[4]), .compare_fault_a(routed[5]),
        .compare_fault_b(routed[6]), .uart_a_receive(routed[7]),
        .uart_a_clear_to_send(routed[8]), .uart_b_receive(routed[9]),
        .uart_b_clear_to_send(routed[10]), .spi_a_data_in(routed[11]),
        .spi_a_clock_in(routed[12]), .spi_a_select_in(routed[13]),
        .spi_b_data_in(routed[14]), .spi_b_clock_in(routed[15]),
        .spi_b_select_in(routed[16]));

    rmsel_pin_model pins (.aclk(aclk), .analog_req(an_req),
        .pin_in(pin_in), .pin_analog(pin_analog));

    // Pin levels as the design sampled them at the last edge.
    always @(posedge aclk) begin
        pin_p <= pin_in;
        an_p  <= pin_analog;
    end

    task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic axw(logic [5:0] a, logic [31:0] d, logic [3:0] s,
                       output logic [1:0] r);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done  = 1'b0;
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= s;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        // Each channel drops its valid only after the edge that takes it.
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : axw

    task automatic axr(logic [5:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axr

    task automatic wr_reg(int i, logic [31:0] d, logic [3:0] s);
        int unsigned bm;
        int unsigned m;
        axw(6'(i * 4), d, s, resp);
        cmp("write resp", {30'h0, RESP_OKAY}, {30'h0, resp});
        bm = {s[1] ? 8'hFF : 8'h00, s[0] ? 8'hFF : 8'h00};
        m  = REG_HAS_HI[i] ? MASK_TWO : MASK_ONE;
        if (!lock) exp_reg[i] = ((exp_reg[i] & ~bm) | (d & bm)) & m;
    endtask : wr_reg

    task automatic rd_reg(int i);
        axr(6'(i * 4), rd, resp);
        cmp($sformatf("reg %0d", i), exp_reg[i], rd);
        cmp("read resp", {30'h0, RESP_OKAY}, {30'h0, resp});
    endtask : rd_reg

    function automatic int fld(int c);
        int s;
        s = CH_SLOT[c];
        return (exp_reg[s / 2] >> (8 * (s % 2))) & 31;
    endfunction : fld

    task automatic rchk(int n);
        int   f;
        logic e;
        repeat (n) begin
            @(posedge aclk);
            #1;
            for (int c = 0; c < NUM_CH; c++) begin
                f = fld(c);
                e = (f < NUM_PINS && an_p[f] === 1'b0) ? pin_p[f] : CH_IDLE[c];
                cmp($sformatf("chan %0d", c), 32'(e), 32'(routed[c]));
            end
        end
    endtask : rchk

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    initial begin
        repeat (30000) @(posedge aclk);
        fails++;
        stop_test();
    end

    initial begin
        {aresetn, lock, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb, an_req} = '0;
        ce = 1'b1;
        void'($urandom(62259));
        for (int i = 0; i < NUM_REGS; i++)
            exp_reg[i] = REG_HAS_HI[i] ? MASK_TWO : MASK_ONE;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < NUM_REGS; i++) rd_reg(i);
        rchk(4);
        $display("test reset done");
        repeat (60) begin
            wr_reg($urandom % NUM_REGS, $urandom, 4'($urandom));
            rd_reg($urandom % NUM_REGS);
        end
        $display("test access done");
        for (int n = 0; n < 32; n++) begin
            for (int i = 0; i < NUM_REGS; i++)
                wr_reg(i, 32'(n) | (32'(n + 1) << 8), 4'h3);
            rchk(3);
        end
        $display("test sweep done");
        an_req <= NUM_PINS'($urandom);
        repeat (10) begin
            for (int i = 0; i < NUM_REGS; i++) wr_reg(i, $urandom, 4'hF);
            rchk(3);
        end
        an_req <= '0;
        $display("test analog done");
        lock <= 1'b1;
        for (int i = 0; i < NUM_REGS; i++) begin
            wr_reg(i, ~exp_reg[i], 4'hF);
            rd_reg(i);
        end
        axr({IDX_STATUS, 2'b00}, rd, resp);
        cmp("lock status", 32'h0000_0001, rd & 32'h0000_0001);
        lock <= 1'b0;
        rchk(3);
        $display("test lock done");
        // Clock enable low must hold every routed level.
        @(posedge aclk);
        ce <= 1'b0;
        #1;
        frz = routed;
        repeat (4) begin
            @(posedge aclk);
            #1;
            cmp("frozen", 32'(frz), 32'(routed));
        end
        @(posedge aclk);
        ce <= 1'b1;
        rchk(3);
        $display("test enable done");
        axr(6'h2C, rd, resp);
        cmp("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        cmp("unmapped data", 32'h0000_0000, rd);
        axw({IDX_STATUS, 2'b00}, 32'hFFFF_FFFF, 4'hF, resp);
        cmp("status write", {30'h0, RESP_SLVERR}, {30'h0, resp});
        $display("test unmapped done");
        stop_test();
    end
endmodule : rmsel_bench
`default_nettype wire
